// ==== rtc_i2c_slave_interface_tb.sv ====
/*
 Testbench for the two-wire slave with a master model and register file.
 Assumes TIMEOUT_CYC is shortened to keep the run brief.
*/
`timescale 1ns/1ps
module rtc_i2c_slave_interface_tb;
  localparam TO = 2000;
  logic       clock, resetn, a, to_seen;
  logic [7:0] d;
  logic [7:0] regs [0:15];
  wire        scl, sda_m, sda_oe, sda_out, wr_en, frz, tmo;
  wire  [3:0] rd_addr, wr_addr;
  wire  [7:0] wr_data;
  wire        sda = sda_m & ~sda_oe;
  int         fails, cmp_count, cyc;
  rtci_slave #(.TIMEOUT_CYC(TO)) dut (.clock(clock), .resetn(resetn),
    .scl_in(scl), .sda_in(sda), .sda_out_ff(sda_out), .sda_oe_ff(sda_oe),
    .rd_addr_ff(rd_addr), .rd_data(regs[rd_addr]), .wr_en_ff(wr_en),
    .wr_addr_ff(wr_addr), .wr_data_ff(wr_data), .freeze_ff(frz),
    .timeout_ff(tmo));
  rtci_master m (.sda(sda), .scl_o(scl), .sda_o(sda_m));
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  always @(posedge clock) begin
    if (wr_en) regs[wr_addr] <= wr_data;
    if (tmo) to_seen <= 1'b1;
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails++;
      wrap_up;
    end
  end
  task chk(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: %h expected %h", $time, seen, exp);
    end
  endtask
  task wrap_up;
    $display("compares %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task t_write;
    m.bus_start;
    m.wbyte(8'ha2, a);
    chk(8'(a), 8'h01);
    chk(8'(frz), 8'h01);
    m.wbyte(8'h3c, a);
    chk(8'(a), 8'h01);
    m.wbyte(8'h55, a);
    m.wbyte(8'haa, a);
    chk(8'(a), 8'h01);
    m.bus_stop;
    repeat (10) @(negedge clock);
    chk(regs[12], 8'h55);
    chk(regs[13], 8'haa);
    chk(8'(frz), 8'h00);
    $display("write test done");
  endtask
  task t_read;
    m.bus_start;
    m.wbyte(8'ha2, a);
    m.wbyte(8'h0c, a);
    m.bus_start;
    m.wbyte(8'ha3, a);
    chk(8'(a), 8'h01);
    m.rbyte(d, 1'b1);
    chk(d, 8'h55);
    m.rbyte(d, 1'b0);
    chk(d, 8'haa);
    // A device that ignored the missing ack would pull within a few clocks
    repeat (8) @(negedge clock);
    chk(8'(sda), 8'h01);
    m.bus_stop;
    m.bus_start;
    m.wbyte(8'ha3, a);
    m.rbyte(d, 1'b0);
    chk(d, 8'h1e);
    m.bus_stop;
    $display("read test done");
  endtask
  task t_foreign;
    m.bus_start;
    m.wbyte(8'ha4, a);
    chk(8'(a), 8'h00);
    m.bus_start;
    m.wbyte(8'h51, a);
    chk(8'(a), 8'h00);
    m.bus_stop;
    $display("foreign address test done");
  endtask
  task t_timeout;
    m.bus_start;
    m.wbyte(8'ha2, a);
    m.wbyte(8'h00, a);
    repeat (TO + 100) @(negedge clock);
    chk(8'(to_seen), 8'h01);
    chk(8'(frz), 8'h00);
    m.wbyte(8'h77, a);
    chk(8'(a), 8'h00);
    m.rbyte(d, 1'b0);
    chk(d, 8'hff);
    m.bus_stop;
    repeat (10) @(negedge clock);
    chk(regs[0], 8'h10);
    m.bus_start;
    m.wbyte(8'ha3, a);
    chk(8'(a), 8'h01);
    m.rbyte(d, 1'b0);
    m.bus_stop;
    $display("timeout test done");
  endtask
  initial begin
    resetn = 1'b0;
    to_seen = 1'b0;
    cyc = 0;
    for (int i = 0; i < 16; i++) regs[i] = 8'h10 + 8'(i);
    repeat (5) @(negedge clock);
    resetn = 1'b1;
    repeat (10) @(negedge clock);
    t_write;
    t_read;
    t_foreign;
    t_timeout;
    wrap_up;
  end
endmodule

// ==== rtci_defs.vh ====
/*
 Constants for the two-wire slave interface of the clock module: the fixed
 slave address, pointer width, filter depth and timeout figures.
 Assumes it is included by bare name from each design file.
*/
`ifndef RTCI_DEFS_VH
`define RTCI_DEFS_VH

`define RTCI_SLAVE_ADDR   7'h51
`define RTCI_ADDR_RD      8'ha3
`define RTCI_ADDR_WR      8'ha2
`define RTCI_PTR_W        4
`define RTCI_FLT_LEN      3
`define RTCI_READ_IDLE    8'hff
`define RTCI_CLK_MHZ      200
`define RTCI_TIMEOUT_MS   1000
`define RTCI_TIMEOUT_CYC  (`RTCI_TIMEOUT_MS * 1000 * `RTCI_CLK_MHZ)

`endif

// ==== rtci_master.sv ====
/*
 Bus master model: drives SCL, shares SDA open drain, 80 ns bit time.
 Assumes a pull-up on SDA; SCL stands high between frames.
*/
`timescale 1ns/1ps
module rtci_master (
  // Bus
  input  wire  sda,
  output logic scl_o,
  output logic sda_o
);
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  task bitx(input logic b, output logic r);
    #20 sda_o = b;
    #20 scl_o = 1'b1;
    r = sda;
    #40 scl_o = 1'b0;
  endtask
  task bus_start;
    #20 sda_o = 1'b1;
    #20 scl_o = 1'b1;
    #40 sda_o = 1'b0;
    #40 scl_o = 1'b0;
  endtask
  task bus_stop;
    #20 sda_o = 1'b0;
    #20 scl_o = 1'b1;
    #40 sda_o = 1'b1;
    #40;
  endtask
  task wbyte(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bitx(b[i], r);
    bitx(1'b1, r);
    ack = !r;
  endtask
  task rbyte(output logic [7:0] d, input logic mack);
    logic r;
    for (int i = 7; i >= 0; i--) bitx(1'b1, d[i]);
    bitx(!mack, r);
  endtask
endmodule

// ==== rtci_monitor.sv ====
/*
 Checker for the two-wire slave, watching the rtci_slave ports only.
 Assumes the bind hands on TIMEOUT_CYC and PTR_W.
*/
`timescale 1ns/1ps
module rtci_monitor #(
  parameter TIMEOUT_CYC = 2000,
  parameter PTR_W       = 4
) (
  // Clock and reset
  input wire             clock,
  input wire             resetn,
  // Bus pins
  input wire             scl_in,
  input wire             sda_in,
  input wire             sda_out_ff,
  input wire             sda_oe_ff,
  // Register file side
  input wire [PTR_W-1:0] rd_addr_ff,
  input wire [7:0]       rd_data,
  input wire             wr_en_ff,
  input wire [PTR_W-1:0] wr_addr_ff,
  input wire [7:0]       wr_data_ff,
  // Status
  input wire             freeze_ff,
  input wire             timeout_ff
);
  int frz_cnt_ff;
  always @(posedge clock or negedge resetn) begin
    if (!resetn)
      frz_cnt_ff <= 0;
    else
      frz_cnt_ff <= freeze_ff ? frz_cnt_ff + 1 : 0;
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  sequence s_drive_rise;
    $rose(sda_oe_ff);
  endsequence
  sequence s_drive_hold;
    sda_oe_ff [*8];
  endsequence
  sda_low_only_a: assert property (sda_oe_ff |-> !sda_out_ff)
    else $error("sda driven high");
  oe_scl_low_a: assert property ($changed(sda_oe_ff) |-> !scl_in)
    else $error("sda changed while scl high");
  ack_hold_a: assert property (s_drive_rise |-> s_drive_hold)
    else $error("sda pull released early");
  wr_in_access_a: assert property (wr_en_ff |-> freeze_ff)
    else $error("write outside an open access");
  to_clear_a: assert property (timeout_ff |-> ##[0:1] !freeze_ff)
    else $error("timeout left access open");
  to_late_a: assert property (frz_cnt_ff <= TIMEOUT_CYC + 8)
    else $error("access outlived the timeout");
  to_early_a: assert property (timeout_ff |-> frz_cnt_ff >= TIMEOUT_CYC - 8)
    else $error("timeout fired early");
  // Freeze drops two cycles after the condition, when SCL may be low again
  stop_scl_a: assert property ($fell(freeze_ff) && !timeout_ff
    && !$past(timeout_ff) |-> $past(scl_in, 2))
    else $error("access closed without scl high");
endmodule
bind rtci_slave rtci_monitor #(.TIMEOUT_CYC(TIMEOUT_CYC), .PTR_W(PTR_W)) mon (
  .clock(clock), .resetn(resetn), .scl_in(scl_in), .sda_in(sda_in),
  .sda_out_ff(sda_out_ff), .sda_oe_ff(sda_oe_ff), .rd_addr_ff(rd_addr_ff),
  .rd_data(rd_data), .wr_en_ff(wr_en_ff), .wr_addr_ff(wr_addr_ff),
  .wr_data_ff(wr_data_ff), .freeze_ff(freeze_ff), .timeout_ff(timeout_ff));

// ==== rtci_slave.v ====
/*
 Two-wire bus slave of the clock module: start/stop detection, address
 match, acknowledge, register pointer and byte shifting, plus bus timeout.
 Assumes SCL and SDA arrive from pins; register storage lives outside and
 answers rd_data combinationally for rd_addr.
*/
`timescale 1ns/1ps
`include "rtci_defs.vh"

module rtci_slave #(
  parameter TIMEOUT_CYC = `RTCI_TIMEOUT_CYC,
  parameter PTR_W       = `RTCI_PTR_W
) (
  // Clock and reset
  input  wire             clock,
  input  wire             resetn,
  // Two-wire bus pins
  input  wire             scl_in,
  input  wire             sda_in,
  output reg              sda_out_ff,
  output reg              sda_oe_ff,
  // Register file access
  output reg  [PTR_W-1:0] rd_addr_ff,
  input  wire [7:0]       rd_data,
  output reg              wr_en_ff,
  output reg  [PTR_W-1:0] wr_addr_ff,
  output reg  [7:0]       wr_data_ff,
  // Status
  output reg              freeze_ff,
  output reg              timeout_ff
);

  localparam ST_IDLE = 3'd0;
  localparam ST_ADDR = 3'd1;
  localparam ST_AACK = 3'd2;
  localparam ST_WBYT = 3'd3;
  localparam ST_WACK = 3'd4;
  localparam ST_RBYT = 3'd5;
  localparam ST_RACK = 3'd6;

  wire scl_f;
  wire sda_f;
  wire to_fire;

  reg             scl_d_ff;
  reg             sda_d_ff;
  reg [2:0]       st_ff;
  reg [3:0]       bit_ff;
  reg [7:0]       sh_ff;
  reg             dir_rd_ff;
  reg             ptr_set_ff;
  reg             dead_ff;
  reg [PTR_W-1:0] ptr_ff;
  reg             active_ff;

  // Filtering costs a few clocks, far inside a 400 kHz bit time
  rtci_sync_filt #(.LEN(`RTCI_FLT_LEN)) u_scl (
    .clock    (clock),
    .resetn   (resetn),
    .pin_in   (scl_in),
    .level_ff (scl_f)
  );

  rtci_sync_filt #(.LEN(`RTCI_FLT_LEN)) u_sda (
    .clock    (clock),
    .resetn   (resetn),
    .pin_in   (sda_in),
    .level_ff (sda_f)
  );

  // Armed from a valid address until stop or start; fires after one second
  rtci_timeout #(.LIMIT(TIMEOUT_CYC)) u_to (
    .clock   (clock),
    .resetn  (resetn),
    .arm     (active_ff),
    .fire_ff (to_fire)
  );

  // Both lines share one filter latency, so a data change never
  // overtakes the clock edge next to it
  wire scl_rise = scl_f & ~scl_d_ff;
  wire scl_fall = ~scl_f & scl_d_ff;
  wire start_c  = scl_f & scl_d_ff & sda_d_ff & ~sda_f;
  wire stop_c   = scl_f & scl_d_ff & ~sda_d_ff & sda_f;
  wire [7:0] rx_byte = {sh_ff[6:0], sda_f};

  // Address byte names this device; the direction bit is not compared
  function addr_hit;
    input [7:0] byte_in;
    begin
      addr_hit = (byte_in[7:1] == `RTCI_SLAVE_ADDR);
    end
  endfunction

  // Pointer wraps within its width, so long bursts roll over
  function [PTR_W-1:0] ptr_next;
    input [PTR_W-1:0] ptr_in;
    begin
      ptr_next = ptr_in + {{(PTR_W-1){1'b0}}, 1'b1};
    end
  endfunction

  // Byte to shift out; a cleared access only ever returns all ones
  function [7:0] tx_byte;
    input       dead_in;
    input [7:0] data_in;
    begin
      if (dead_in)
        tx_byte = `RTCI_READ_IDLE;
      else
        tx_byte = data_in;
    end
  endfunction

  // First read bit: pull low only for a zero, never drive high
  function first_low;
    input       dead_in;
    input [7:0] data_in;
    reg   [7:0] bits;
    begin
      bits      = tx_byte(dead_in, data_in);
      first_low = ~bits[7];
    end
  endfunction

  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      scl_d_ff   <= 1'b1;
      sda_d_ff   <= 1'b1;
      st_ff      <= ST_IDLE;
      bit_ff     <= 4'h0;
      sh_ff      <= 8'h00;
      dir_rd_ff  <= 1'b0;
      ptr_set_ff <= 1'b0;
      dead_ff    <= 1'b0;
      ptr_ff     <= {PTR_W{1'b0}};
      active_ff  <= 1'b0;
      sda_out_ff <= 1'b0;
      sda_oe_ff  <= 1'b0;
      rd_addr_ff <= {PTR_W{1'b0}};
      wr_en_ff   <= 1'b0;
      wr_addr_ff <= {PTR_W{1'b0}};
      wr_data_ff <= 8'h00;
      freeze_ff  <= 1'b0;
      timeout_ff <= 1'b0;
    end else begin
      scl_d_ff   <= scl_f;
      sda_d_ff   <= sda_f;
      wr_en_ff   <= 1'b0;
      timeout_ff <= 1'b0;
      sda_out_ff <= 1'b0;
      // Freeze trails the open access by a cycle and drops right after a
      // timeout has cleared it
      freeze_ff  <= active_ff & ~dead_ff;
      // Register file sees the pointer a cycle late; it is read only at an
      // SCL fall, long after the pointer last moved
      rd_addr_ff <= ptr_ff;
      if (to_fire) begin
        // Abandon: release SDA and wait for a fresh start
        st_ff      <= ST_IDLE;
        sda_oe_ff  <= 1'b0;
        dead_ff    <= 1'b1;
        active_ff  <= 1'b0;
        timeout_ff <= 1'b1;
      end else if (start_c) begin
        // Repeated start ends any write and reopens address phase
        st_ff      <= ST_ADDR;
        bit_ff     <= 4'h0;
        sda_oe_ff  <= 1'b0;
        ptr_set_ff <= 1'b0;
        dead_ff    <= 1'b0;
        active_ff  <= 1'b0;
      end else if (stop_c) begin
        st_ff     <= ST_IDLE;
        sda_oe_ff <= 1'b0;
        active_ff <= 1'b0;
      end else begin
        case (st_ff)
          ST_IDLE: begin
            // Foreign address or finished read waits here for a start
            sda_oe_ff <= 1'b0;
          end
          ST_ADDR: begin
            if (scl_rise) begin
              sh_ff  <= rx_byte;
              bit_ff <= bit_ff + 4'h1;
            end
            // Act on the falling edge so SDA moves only while SCL low
            if (scl_fall && bit_ff == 4'h8) begin
              dir_rd_ff <= sh_ff[0];
              if (addr_hit(sh_ff)) begin
                sda_oe_ff <= 1'b1;
                active_ff <= 1'b1;
                st_ff     <= ST_AACK;
              end else begin
                sda_oe_ff <= 1'b0;
                st_ff     <= ST_IDLE;
              end
            end
          end
          ST_AACK: begin
            if (scl_fall) begin
              bit_ff <= 4'h0;
              if (dir_rd_ff) begin
                // Read from current pointer: the value last set, else last access plus one
                sh_ff     <= tx_byte(dead_ff, rd_data);
                sda_oe_ff <= first_low(dead_ff, rd_data);
                st_ff     <= ST_RBYT;
              end else begin
                sda_oe_ff <= 1'b0;
                st_ff     <= ST_WBYT;
              end
            end
          end
          ST_WBYT: begin
            if (scl_rise) begin
              sh_ff  <= rx_byte;
              bit_ff <= bit_ff + 4'h1;
            end
            if (scl_fall && bit_ff == 4'h8) begin
              sda_oe_ff <= 1'b1;
              st_ff     <= ST_WACK;
              if (!ptr_set_ff) begin
                ptr_ff     <= sh_ff[PTR_W-1:0];
                ptr_set_ff <= 1'b1;
              end else begin
                wr_en_ff   <= ~dead_ff;
                wr_addr_ff <= ptr_ff;
                wr_data_ff <= sh_ff;
                ptr_ff     <= ptr_next(ptr_ff);
              end
            end
          end
          ST_WACK: begin
            // No limit on bytes per transfer
            if (scl_fall) begin
              sda_oe_ff <= 1'b0;
              bit_ff    <= 4'h0;
              st_ff     <= ST_WBYT;
            end
          end
          ST_RBYT: begin
            if (scl_fall) begin
              if (bit_ff == 4'h7) begin
                sda_oe_ff <= 1'b0; // Release for master acknowledge
                // Pointer steps after the eighth bit, acknowledged or not
                ptr_ff    <= ptr_next(ptr_ff);
                st_ff     <= ST_RACK;
              end else begin
                sh_ff     <= {sh_ff[6:0], 1'b1};
                sda_oe_ff <= ~sh_ff[6] & ~dead_ff;
                bit_ff    <= bit_ff + 4'h1;
              end
            end
          end
          ST_RACK: begin
            if (scl_rise)
              sh_ff[0] <= sda_f; // Master acknowledge sample
            if (scl_fall) begin
              bit_ff <= 4'h0;
              if (!sh_ff[0]) begin
                sh_ff     <= tx_byte(dead_ff, rd_data);
                sda_oe_ff <= first_low(dead_ff, rd_data);
                st_ff     <= ST_RBYT;
              end else begin
                sda_oe_ff <= 1'b0;
                st_ff     <= ST_IDLE;
              end
            end
          end
          default: begin
            st_ff     <= ST_IDLE;
            sda_oe_ff <= 1'b0;
          end
        endcase
      end
    end
  end

endmodule

// ==== rtci_sync_filt.v ====
/*
 Two-flop synchroniser followed by an all-equal glitch filter.
 Assumes an asynchronous pin on the input; output is a clean level on clock.
*/
`timescale 1ns/1ps
`include "rtci_defs.vh"

module rtci_sync_filt #(
  parameter LEN = `RTCI_FLT_LEN
) (
  // Clock and reset
  input  wire clock,
  input  wire resetn,
  // Pin in, filtered level out
  input  wire pin_in,
  output reg  level_ff
);

  reg           meta_ff;
  reg           sync_ff;
  reg [LEN-1:0] hist_ff;

  // Level changes only after LEN equal samples, so spikes shorter than that
  // never reach the condition detectors
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      meta_ff  <= 1'b1;
      sync_ff  <= 1'b1;
      hist_ff  <= {LEN{1'b1}};
      level_ff <= 1'b1;
    end else begin
      meta_ff <= pin_in;
      sync_ff <= meta_ff;
      hist_ff <= {hist_ff[LEN-2:0], sync_ff};
      if (&hist_ff)
        level_ff <= 1'b1;
      else if (~|hist_ff)
        level_ff <= 1'b0;
    end
  end

endmodule

// ==== rtci_timeout.v ====
/*
 Bus timeout counter: runs while armed, fires a one-cycle pulse at LIMIT.
 Assumes arm is a level from the same clock domain.
*/
`timescale 1ns/1ps
`include "rtci_defs.vh"

module rtci_timeout #(
  parameter LIMIT = `RTCI_TIMEOUT_CYC
) (
  // Clock and reset
  input  wire clock,
  input  wire resetn,
  // Control
  input  wire arm,
  output reg  fire_ff
);

  reg [31:0] cnt_ff;

  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      cnt_ff  <= 32'h0;
      fire_ff <= 1'b0;
    end else if (!arm) begin
      cnt_ff  <= 32'h0;
      fire_ff <= 1'b0;
    end else begin
      fire_ff <= (cnt_ff == LIMIT - 1);
      if (cnt_ff != LIMIT)
        cnt_ff <= cnt_ff + 32'h1;
    end
  end

endmodule
